// ==== khm_defs.vh ====
`ifndef KHM_DEFS_VH
`define KHM_DEFS_VH

// ---------------------------------------------------------------------------
// Host port addresses
// ---------------------------------------------------------------------------
`define KHM_HOST_DATA_ADDR   8'h60
`define KHM_HOST_CMD_ADDR    8'h64
`define KHM_HOST_ADDR_BIT2   2

// ---------------------------------------------------------------------------
// Status byte field positions and reset value
// ---------------------------------------------------------------------------
`define KHM_ST_OBF           0
`define KHM_ST_IBF           1
`define KHM_ST_CMD           3
`define KHM_STATUS_RESET     8'h00
`define KHM_ST_CPU_WMASK     8'hF4

// ---------------------------------------------------------------------------
// Port 2 bit positions
// ---------------------------------------------------------------------------
`define KHM_P2_A20           1
`define KHM_P2_MOUSE_DATA_LINE          2
`define KHM_P2_MCLK          3
`define KHM_P2_KBD_HOST_IRQ          4
`define KHM_P2_MOUSE_HOST_IRQ          5
`define KHM_P2_KEYBOARD_CLOCK_LINE          6
`define KHM_P2_KEYBOARD_DATA_LINE          7
`define KHM_PORT_RESET       8'hFF

// ---------------------------------------------------------------------------
// Timing: active pull-up window of the quasi-bidirectional pins
// ---------------------------------------------------------------------------
`define KHM_CLK_HZ           50000000
`define KHM_PULLUP_NS        500
`define KHM_PULLUP_CYCLES    ((`KHM_PULLUP_NS * (`KHM_CLK_HZ / 1000000)) / 1000)
`define KHM_PULLUP_CW        5

// ---------------------------------------------------------------------------
// Power states
// ---------------------------------------------------------------------------
`define KHM_PWR_RUN          2'h0
`define KHM_PWR_SOFT         2'h1
`define KHM_PWR_HARD         2'h2

`endif

// ==== khm_quasi_pin.v ====
`timescale 1ns/1ps
`include "khm_defs.vh"

// ---------------------------------------------------------------------------
// One quasi-bidirectional port pin with a timed active pull-up.
// ---------------------------------------------------------------------------
module khm_quasi_pin (
    input  wire clock,
    input  wire reset_n,
    input  wire port_value,
    input  wire open_drain,
    output reg  pin_out,
    output reg  pin_oe
);

    reg [`KHM_PULLUP_CW-1:0] pull_cnt_reg;
    reg                      last_value_reg;

    // Full-width load value of the pull-up window, cut to the counter width on purpose.
    wire [31:0]              pull_load = `KHM_PULLUP_CYCLES;

    // A zero drives low; unless open_drain is set, a rising one drives high for a short window, then releases.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pull_cnt_reg   <= {`KHM_PULLUP_CW{1'b0}};
            last_value_reg <= 1'b1;
            pin_out        <= 1'b1;
            pin_oe         <= 1'b0;
        end else begin
            last_value_reg <= port_value;
            if (!port_value) begin
                pin_out      <= 1'b0;
                pin_oe       <= 1'b1;
                pull_cnt_reg <= {`KHM_PULLUP_CW{1'b0}};
            end else if (open_drain) begin
                pin_out      <= 1'b1;
                pin_oe       <= 1'b0;
                pull_cnt_reg <= {`KHM_PULLUP_CW{1'b0}};
            end else if (!last_value_reg) begin
                pin_out      <= 1'b1;
                pin_oe       <= 1'b1;
                pull_cnt_reg <= pull_load[`KHM_PULLUP_CW-1:0];
            end else if (pull_cnt_reg != {`KHM_PULLUP_CW{1'b0}}) begin
                pull_cnt_reg <= pull_cnt_reg - 1'b1;
                pin_out      <= 1'b1;
                pin_oe       <= (pull_cnt_reg != 1);
            end else begin
                pin_out <= 1'b1;
                pin_oe  <= 1'b0;
            end
        end
    end

endmodule // khm_quasi_pin

// ==== khm_host_mailbox.v ====
`timescale 1ns/1ps
`include "khm_defs.vh"

module khm_host_mailbox (
    input  wire       clock,
    input  wire       reset_n,
    // Host port.
    input  wire [7:0] host_addr,
    input  wire       host_wr,
    input  wire       host_rd,
    input  wire [7:0] host_wdata,
    output reg  [7:0] host_rdata,
    output reg        kbd_host_irq,
    output reg        mouse_host_irq,
    // Embedded CPU side.
    input  wire       cpu_buffer_wr,
    input  wire [7:0] cpu_buffer_wdata,
    input  wire       cpu_input_rd,
    output reg  [7:0] cpu_input_buffer,
    input  wire       cpu_status_wr,
    input  wire [7:0] cpu_status_wdata,
    output reg  [7:0] cpu_status,
    input  wire       cpu_port2_wr,
    input  wire [7:0] cpu_port2_wdata,
    input  wire [2:0] cpu_port1_quasi_wdata,
    input  wire       cpu_port1_quasi_wr,
    input  wire       cpu_en_flags,
    input  wire       cpu_ibf_int_en,
    input  wire       cpu_halt,
    input  wire       cpu_stop,
    input  wire       cfg_open_drain,
    input  wire       cfg_gp_input,
    input  wire       cfg_gp_invert,
    output reg        cpu_ibf_int,
    output reg        cpu_alu_clk_en,
    output reg        cpu_osc_en,
    output reg        cpu_wake_call,
    output reg        cpu_wake_next,
    output reg        test_input_zero,
    output reg        test_input_one,
    output reg        port1_bit0_kbd_dat_sense,
    output reg        port1_bit1_mouse_dat_sense,
    // Keyboard and mouse lines, open drain.
    input  wire       keyboard_clock_line_in,
    output reg        keyboard_clock_line_oe,
    input  wire       keyboard_data_line_in,
    output reg        keyboard_data_line_oe,
    input  wire       mouse_clock_line_in,
    output reg        mouse_clock_line_oe,
    input  wire       mouse_data_line_in,
    output reg        mouse_data_line_oe,
    output reg        addr_line20_gate,
    // Quasi-bidirectional pins P17, P16, P12 order: bit 2, 1, 0.
    output wire [2:0] quasi_pin_out,
    output wire [2:0] quasi_pin_oe
);

    // -----------------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------------
    reg [7:0] input_buf_reg;
    reg [7:0] output_buf_reg;
    reg [7:0] status_reg;
    reg [7:0] port2_reg;
    reg [2:0] quasi_reg;
    reg       flags_en_reg;
    reg [1:0] pwr_reg;

    wire host_is_data = (host_addr == `KHM_HOST_DATA_ADDR);
    wire host_is_cmd  = (host_addr == `KHM_HOST_CMD_ADDR);
    wire host_in_wr   = host_wr && (host_is_data || host_is_cmd);
    wire host_data_rd = host_rd && host_is_data;

    // Controller mode forbids input or inverted configuration of the quasi pins.
    wire gp_override  = 1'b0 & (cfg_gp_input | cfg_gp_invert);

    // -----------------------------------------------------------------------
    // Mailbox registers and status flags
    // -----------------------------------------------------------------------
    // Hardware sets win over clears in the same cycle.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            input_buf_reg  <= 8'h00;
            output_buf_reg <= 8'h00;
            status_reg     <= `KHM_STATUS_RESET;
            flags_en_reg   <= 1'b0;
        end else begin
            if (cpu_en_flags) begin
                flags_en_reg <= 1'b1;
            end
            if (cpu_status_wr) begin
                status_reg <= (status_reg & ~`KHM_ST_CPU_WMASK)
                              | (cpu_status_wdata & `KHM_ST_CPU_WMASK);
            end
            if (cpu_input_rd) begin
                status_reg[`KHM_ST_IBF] <= 1'b0;
            end
            if (host_data_rd && flags_en_reg) begin
                status_reg[`KHM_ST_OBF] <= 1'b0;
            end
            if (host_in_wr) begin
                input_buf_reg           <= host_wdata;
                status_reg[`KHM_ST_IBF] <= 1'b1;
                status_reg[`KHM_ST_CMD] <= host_addr[`KHM_HOST_ADDR_BIT2];
            end
            if (cpu_buffer_wr) begin
                output_buf_reg          <= cpu_buffer_wdata;
                status_reg[`KHM_ST_OBF] <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Host read data; a status read has no side effect
    // -----------------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            if (host_is_cmd) begin
                host_rdata <= status_reg;
            end else if (host_is_data) begin
                host_rdata <= output_buf_reg;
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Port 2 and port 1 quasi latch
    // -----------------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            port2_reg <= `KHM_PORT_RESET;
            quasi_reg <= 3'h7;
        end else begin
            if (cpu_port2_wr) begin
                port2_reg <= cpu_port2_wdata;
            end
            if (cpu_port1_quasi_wr) begin
                quasi_reg <= cpu_port1_quasi_wdata ^ {3{gp_override}};
            end
        end
    end

    // -----------------------------------------------------------------------
    // Host interrupts, A20 gate, line drives and read-back
    // -----------------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            kbd_host_irq               <= 1'b0;
            mouse_host_irq             <= 1'b0;
            addr_line20_gate           <= 1'b1;
            keyboard_clock_line_oe     <= 1'b1;
            keyboard_data_line_oe      <= 1'b1;
            mouse_clock_line_oe        <= 1'b1;
            mouse_data_line_oe         <= 1'b1;
            test_input_zero            <= 1'b0;
            test_input_one             <= 1'b0;
            port1_bit0_kbd_dat_sense   <= 1'b0;
            port1_bit1_mouse_dat_sense <= 1'b0;
            cpu_status                 <= `KHM_STATUS_RESET;
            cpu_input_buffer           <= 8'h00;
            cpu_ibf_int                <= 1'b0;
        end else begin
            if (flags_en_reg) begin
                kbd_host_irq   <= port2_reg[`KHM_P2_KBD_HOST_IRQ] & status_reg[`KHM_ST_OBF];
                mouse_host_irq <= port2_reg[`KHM_P2_MOUSE_HOST_IRQ]
                                  & ~status_reg[`KHM_ST_IBF];
            end else begin
                kbd_host_irq   <= port2_reg[`KHM_P2_KBD_HOST_IRQ];
                mouse_host_irq <= port2_reg[`KHM_P2_MOUSE_HOST_IRQ];
            end
            addr_line20_gate       <= port2_reg[`KHM_P2_A20];
            // Inverted port bit: a one pulls the line low.
            keyboard_clock_line_oe <= port2_reg[`KHM_P2_KEYBOARD_CLOCK_LINE];
            keyboard_data_line_oe  <= port2_reg[`KHM_P2_KEYBOARD_DATA_LINE];
            mouse_clock_line_oe    <= port2_reg[`KHM_P2_MCLK];
            mouse_data_line_oe     <= port2_reg[`KHM_P2_MOUSE_DATA_LINE];
            test_input_zero            <= keyboard_clock_line_in;
            port1_bit0_kbd_dat_sense   <= keyboard_data_line_in;
            test_input_one             <= mouse_clock_line_in;
            port1_bit1_mouse_dat_sense <= mouse_data_line_in;
            cpu_status       <= status_reg;
            cpu_input_buffer <= input_buf_reg;
            cpu_ibf_int      <= status_reg[`KHM_ST_IBF] & cpu_ibf_int_en;
        end
    end

    // -----------------------------------------------------------------------
    // Power management: soft and hard powerdown with wake on host write
    // -----------------------------------------------------------------------
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pwr_reg        <= `KHM_PWR_RUN;
            cpu_alu_clk_en <= 1'b1;
            cpu_osc_en     <= 1'b1;
            cpu_wake_call  <= 1'b0;
            cpu_wake_next  <= 1'b0;
        end else begin
            cpu_wake_call <= 1'b0;
            cpu_wake_next <= 1'b0;
            case (pwr_reg)
                `KHM_PWR_RUN: begin
                    if (cpu_stop) begin
                        pwr_reg        <= `KHM_PWR_HARD;
                        cpu_alu_clk_en <= 1'b0;
                        cpu_osc_en     <= 1'b0;
                    end else if (cpu_halt) begin
                        pwr_reg        <= `KHM_PWR_SOFT;
                        cpu_alu_clk_en <= 1'b0;
                    end
                end
                `KHM_PWR_SOFT, `KHM_PWR_HARD: begin
                    if (host_in_wr) begin
                        pwr_reg        <= `KHM_PWR_RUN;
                        cpu_alu_clk_en <= 1'b1;
                        cpu_osc_en     <= 1'b1;
                        cpu_wake_call  <= cpu_ibf_int_en;
                        cpu_wake_next  <= ~cpu_ibf_int_en;
                    end
                end
                default: begin
                    pwr_reg        <= `KHM_PWR_RUN;
                    cpu_alu_clk_en <= 1'b1;
                    cpu_osc_en     <= 1'b1;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------------
    // Quasi-bidirectional pins
    // -----------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_quasi
            khm_quasi_pin u_pin (
                .clock      (clock),
                .reset_n    (reset_n),
                .port_value (quasi_reg[gi]),
                .open_drain (cfg_open_drain),
                .pin_out    (quasi_pin_out[gi]),
                .pin_oe     (quasi_pin_oe[gi])
            );
        end
    endgenerate

endmodule // khm_host_mailbox

// ==== khm_host_mailbox_properties.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Port-level properties of the host mailbox.
// ---------------------------------------------------------------------------
module khm_host_mailbox_props (
    input wire       clock,
    input wire       reset_n,
    input wire [7:0] host_addr,
    input wire       host_wr,
    input wire       host_rd,
    input wire [7:0] host_rdata,
    input wire       kbd_host_irq,
    input wire       mouse_host_irq,
    input wire       cpu_buffer_wr,
    input wire       cpu_input_rd,
    input wire [7:0] cpu_status,
    input wire       cpu_port2_wr,
    input wire [7:0] cpu_port2_wdata,
    input wire       cpu_en_flags,
    input wire       keyboard_clock_line_oe,
    input wire       keyboard_data_line_oe,
    input wire       mouse_clock_line_oe,
    input wire       mouse_data_line_oe,
    input wire       addr_line20_gate,
    input wire [2:0] quasi_pin_out,
    input wire [2:0] quasi_pin_oe
);
    reg [7:0] p2_reg;
    reg       flags_reg;

    // Shadow copies of the port 2 latch and of the sticky flag enable.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            p2_reg    <= 8'hFF;
            flags_reg <= 1'b0;
        end else begin
            if (cpu_port2_wr) p2_reg <= cpu_port2_wdata;
            if (cpu_en_flags) flags_reg <= 1'b1;
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_data_write_flags: assert property (host_wr && host_addr == 8'h60
        |-> ##2 cpu_status[1] && !cpu_status[3]) else $error("data write flags wrong");
    a_cmd_write_flags: assert property (host_wr && host_addr == 8'h64
        |-> ##2 cpu_status[1] && cpu_status[3]) else $error("command write flags wrong");
    a_buffer_sets_full: assert property (cpu_buffer_wr |-> ##2 cpu_status[0])
        else $error("output full not set");
    a_input_read_clears: assert property (cpu_input_rd && !(host_wr &&
        (host_addr == 8'h60 || host_addr == 8'h64)) |-> ##2 !cpu_status[1])
        else $error("input full not cleared");
    a_status_read_quiet: assert property (host_rd && host_addr == 8'h64
        |=> host_rdata == cpu_status) else $error("status read mismatch");
    a_unmapped_read_zero: assert property (host_rd && host_addr != 8'h60
        && host_addr != 8'h64 |=> host_rdata == 8'h00) else $error("unmapped read not zero");
    a_irq_follow: assert property ($past(reset_n) |->
        kbd_host_irq == ($past(p2_reg[4]) & (!$past(flags_reg) | cpu_status[0]))
        && mouse_host_irq == ($past(p2_reg[5]) & (!$past(flags_reg) | !cpu_status[1])))
        else $error("host interrupt outputs wrong");
    a_port_lines_map: assert property (cpu_port2_wr ##1 !cpu_port2_wr |-> ##1
        {addr_line20_gate, keyboard_clock_line_oe, keyboard_data_line_oe, mouse_clock_line_oe,
        mouse_data_line_oe} == {p2_reg[1], p2_reg[6], p2_reg[7], p2_reg[3], p2_reg[2]})
        else $error("port 2 line mapping wrong");
    a_quasi_pullup_time: assert property ($rose(quasi_pin_oe[0] & quasi_pin_out[0])
        |-> ##24 quasi_pin_oe[0] ##1 !quasi_pin_oe[0]) else $error("pull-up window wrong");
endmodule // khm_host_mailbox_props

bind khm_host_mailbox khm_host_mailbox_props i_khm_host_mailbox_props (.*);

// ==== khm_line_partner.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Keyboard and mouse devices on the four open-drain lines, with pull-ups.
// ---------------------------------------------------------------------------
module khm_line_partner (
    input  wire [3:0] dut_oe,
    input  wire [3:0] dev_pull,
    output wire [3:0] line
);
    // A line sits high on its pull-up and goes low when either party sinks it.
    assign line = ~(dut_oe | dev_pull);
endmodule // khm_line_partner

// ==== test_kbd_ctrl_host_mailbox.sv ====
`timescale 1ns/1ps
module test_kbd_ctrl_host_mailbox;
    reg clock, reset_n, host_wr, host_rd, cpu_buffer_wr, cpu_input_rd, cpu_status_wr;
    reg cpu_port2_wr, cpu_port1_quasi_wr, cpu_en_flags, cpu_ibf_int_en, cpu_halt, cpu_stop;
    reg cfg_open_drain, cfg_gp_input, cfg_gp_invert, seen_call, seen_next;
    reg [7:0] host_addr, host_wdata, cpu_buffer_wdata, cpu_status_wdata, cpu_port2_wdata;
    reg [2:0] cpu_port1_quasi_wdata;
    reg [3:0] dev_pull;
    reg [31:0] seed, r;
    integer num_errors, checks_done, i, k;
    wire [7:0] host_rdata, cpu_input_buffer, cpu_status;
    wire kbd_host_irq, mouse_host_irq, cpu_ibf_int, cpu_alu_clk_en, cpu_osc_en;
    wire cpu_wake_call, cpu_wake_next, test_input_zero, test_input_one, addr_line20_gate;
    wire port1_bit0_kbd_dat_sense, port1_bit1_mouse_dat_sense;
    wire keyboard_clock_line_in, keyboard_clock_line_oe, keyboard_data_line_in;
    wire keyboard_data_line_oe, mouse_clock_line_in, mouse_clock_line_oe;
    wire mouse_data_line_in, mouse_data_line_oe;
    wire [2:0] quasi_pin_out, quasi_pin_oe;

    khm_host_mailbox i_khm_host_mailbox (.*);
    khm_line_partner i_khm_line_partner (
        .dut_oe({keyboard_clock_line_oe, keyboard_data_line_oe, mouse_clock_line_oe,
            mouse_data_line_oe}),
        .dev_pull(dev_pull),
        .line({keyboard_clock_line_in, keyboard_data_line_in, mouse_clock_line_in,
            mouse_data_line_in}));

    // Clock at 50 MHz and latches that catch the one-cycle wake pulses.
    always #10 clock = ~clock;
    always @(posedge clock) begin
        if (cpu_wake_call) seen_call <= 1'b1;
        if (cpu_wake_next) seen_next <= 1'b1;
    end

    function automatic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic [7:0] status_of(input cmd, input input_full_flag, input output_full_flag);
        return {4'h0, cmd, 1'b0, input_full_flag, output_full_flag};
    endfunction

    task chk(input string what, input [7:0] exp, input [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            num_errors = num_errors + 1;
        end
    endtask

    task step(input integer n);
        repeat (n) @(negedge clock);
    endtask

    task hw(input [7:0] a, input [7:0] d);
        host_addr = a;
        host_wdata = d;
        host_wr = 1'b1;
        step(1);
        host_wr = 1'b0;
    endtask

    task hr(input [7:0] a);
        host_addr = a;
        host_rd = 1'b1;
        step(1);
        host_rd = 1'b0;
    endtask

    // One-cycle CPU strobe: 0 buffer, 1 input read, 2 port 2, 3 quasi, 4 flags,
    // 5 halt, 6 stop, 7 status write.
    task cpu_op(input [2:0] n, input [7:0] d);
        {cpu_buffer_wdata, cpu_port2_wdata, cpu_status_wdata} = {d, d, d};
        cpu_port1_quasi_wdata = d[2:0];
        {cpu_status_wr, cpu_stop, cpu_halt, cpu_en_flags, cpu_port1_quasi_wr, cpu_port2_wr,
            cpu_input_rd, cpu_buffer_wr} = 8'h01 << n;
        step(1);
        {cpu_status_wr, cpu_stop, cpu_halt, cpu_en_flags, cpu_port1_quasi_wr, cpu_port2_wr,
            cpu_input_rd, cpu_buffer_wr} = 8'h00;
    endtask

    task give_verdict;
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        #1000000;
        num_errors = num_errors + 1;
        give_verdict;
    end

    // Main sequence.
    initial begin
        {clock, reset_n, host_wr, host_rd, cpu_buffer_wr, cpu_input_rd, cpu_status_wr} = 7'h00;
        {cpu_port2_wr, cpu_port1_quasi_wr, cpu_en_flags, cpu_ibf_int_en, cpu_halt} = 5'h00;
        {cpu_stop, cfg_open_drain, cfg_gp_input, cfg_gp_invert, seen_call, seen_next} = 6'h00;
        {host_addr, host_wdata, cpu_buffer_wdata, cpu_status_wdata, cpu_port2_wdata} = 40'h0;
        {cpu_port1_quasi_wdata, dev_pull, num_errors, checks_done, seed} = {7'h00, 64'h0, 32'd77};
        step(4);
        chk("irq in reset", 8'h00, {kbd_host_irq, mouse_host_irq});
        chk("lines in reset", 8'h0F, {keyboard_clock_line_oe, keyboard_data_line_oe,
            mouse_clock_line_oe, mouse_data_line_oe});
        reset_n = 1'b1;
        step(2);
        hr(8'h64);
        chk("status after reset", 8'h00, host_rdata);
        hr(8'h61);
        chk("unmapped read", 8'h00, host_rdata);
        for (i = 0; i < 16; i = i + 1) begin
            r = xs();
            hw({5'h0C, r[2], 2'h0}, r[15:8]);
            step(1);
            chk("input buffer", r[15:8], cpu_input_buffer);
            chk("command flag", r[2], cpu_status[3]);
            cpu_op(0, r[23:16]);
            step(1);
            hr(8'h60);
            chk("data read", r[23:16], host_rdata);
            step(1);
            hr(8'h64);
            chk("status read", status_of(r[2], 1'b1, 1'b1), host_rdata);
            cpu_op(1, 8'h00);
            step(1);
            chk("input full cleared", 8'h00, cpu_status[1]);
        end
        for (i = 0; i < 8; i = i + 1) begin
            r = xs();
            dev_pull = r[11:8];
            cpu_op(2, r[7:0]);
            step(2);
            chk("irq mirror", r[5:4], {mouse_host_irq, kbd_host_irq});
            chk("gate", r[1], addr_line20_gate);
            chk("line sense", ~({r[6], r[7], r[3], r[2]} | dev_pull) & 8'h0F, {test_input_zero,
                port1_bit0_kbd_dat_sense, test_input_one, port1_bit1_mouse_dat_sense});
        end
        dev_pull = 4'h0;
        cpu_op(2, 8'h30);
        cpu_op(4, 8'h00);
        hr(8'h60);
        step(1);
        chk("read clears", 8'h00, {kbd_host_irq, cpu_status[0]});
        chk("mouse irq idle", 8'h01, mouse_host_irq);
        cpu_op(0, 8'hA5);
        step(1);
        chk("kbd irq raised", 8'h01, kbd_host_irq);
        hw(8'h64, 8'h5A);
        step(1);
        chk("mouse irq busy", 8'h00, mouse_host_irq);
        cpu_op(1, 8'h00);
        cpu_op(2, 8'h20);
        step(1);
        chk("irq gated", 8'h02, {mouse_host_irq, kbd_host_irq});
        cpu_op(7, 8'hFF);
        step(1);
        hr(8'h64);
        chk("cpu status write", 8'hFD, host_rdata);
        cpu_op(7, 8'h00);
        {cfg_gp_input, cfg_gp_invert} = 2'h3;
        cpu_op(3, 8'h00);
        step(2);
        chk("quasi low", 8'h07, {quasi_pin_out, quasi_pin_oe});
        cpu_op(3, 8'h07);
        step(2);
        chk("quasi pull-up", 8'h3F, {quasi_pin_out, quasi_pin_oe});
        step(30);
        chk("quasi released", 8'h38, {quasi_pin_out, quasi_pin_oe});
        cfg_open_drain = 1'b1;
        cpu_op(3, 8'h00);
        step(2);
        chk("drain low", 8'h07, {quasi_pin_out, quasi_pin_oe});
        cpu_op(3, 8'h07);
        step(2);
        chk("drain release", 8'h00, quasi_pin_oe);
        cpu_ibf_int_en = 1'b1;
        cpu_op(5, 8'h00);
        step(1);
        chk("soft powerdown", 8'h01, {cpu_alu_clk_en, cpu_osc_en});
        hw(8'h60, 8'h11);
        for (k = 0; k < 8 && seen_call !== 1'b1; k = k + 1) step(1);
        chk("wake call", 8'h03, {seen_call, cpu_alu_clk_en});
        if (seen_call !== 1'b1) give_verdict;
        chk("cpu input interrupt", 8'h01, cpu_ibf_int);
        cpu_op(1, 8'h00);
        step(1);
        chk("cpu interrupt withdrawn", 8'h00, cpu_ibf_int);
        cpu_ibf_int_en = 1'b0;
        cpu_op(6, 8'h00);
        step(1);
        chk("hard powerdown", 8'h00, cpu_osc_en);
        hw(8'h60, 8'h22);
        for (k = 0; k < 8 && seen_next !== 1'b1; k = k + 1) step(1);
        chk("wake next", 8'h03, {seen_next, cpu_osc_en});
        give_verdict;
    end
endmodule // test_kbd_ctrl_host_mailbox
